/* verilog/fsc_handler.sv */
`timescale 1ns/1ps
module fsc_handler #(
    parameter int NBLK = fsc_pkg::BLOCK_COUNT,
    parameter int BSZ  = fsc_pkg::BLOCK_BYTES
) (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // Request byte stream
    input  wire logic        REQ_VALID,
    input  wire logic [7:0]  REQ_DATA,
    input  wire logic        REQ_LAST,
    input  wire logic [15:0] REQ_CLUSTER,
    input  wire logic [7:0]  REQ_DST_EP,
    input  wire logic [7:0]  REQ_SRC_EP,
    input  wire logic        REQ_BCAST,
    output logic             REQ_READY,
    // Response byte stream
    output logic             RSP_VALID,
    output logic [7:0]       RSP_DATA,
    output logic             RSP_LAST,
    output logic [7:0]       RSP_DST_EP,
    input  wire logic        RSP_READY,
    // Storage read port
    input  wire logic [15:0] MEM_RADDR,
    output logic [7:0]       MEM_RDATA,
    // APB
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ
);
    import fsc_pkg::*;

    localparam int MEMW = NBLK * BSZ;
    localparam int AW   = $clog2(MEMW);

    typedef enum logic [4:0] {
        FSC_IDLE  = 5'b00001,
        FSC_RECV  = 5'b00010,
        FSC_EXEC  = 5'b00100,
        FSC_ERASE = 5'b01000,
        FSC_SEND  = 5'b10000
    } fsc_state_e;

    // =========================================================
    // Reset synchroniser
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // =========================================================
    // Storage array, no reset: contents are non-volatile by intent
    logic [7:0] mem [MEMW];
    logic [7:0] mem_rdata_reg;

    // Header byte index decode, used by the response only
    function automatic logic [7:0] hdr_byte(input logic [3:0] idx, input logic [7:0] c, input logic [7:0] o,
                                            input logic [15:0] b, input logic [15:0] s, input logic [15:0] l);
        logic [7:0] r;
        r = 8'h00;
        unique case (idx)
            OFS_CODE:      r = c;
            OFS_OPTION:    r = o;
            OFS_BLOCK_HI:  r = b[15:8];
            OFS_BLOCK_LO:  r = b[7:0];
            OFS_OFFSET_HI: r = s[15:8];
            OFS_OFFSET_LO: r = s[7:0];
            OFS_LENGTH_HI: r = l[15:8];
            OFS_LENGTH_LO: r = l[7:0];
            default:       r = 8'h00;
        endcase
        return r;
    endfunction

    // =========================================================
    // Command state
    fsc_state_e  state_reg,   state_next;
    logic [3:0]  idx_reg,     idx_next;
    logic [7:0]  code_reg,    code_next;
    logic [7:0]  opt_reg,     opt_next;
    logic [15:0] blk_reg,     blk_next;
    logic [15:0] ofs_reg,     ofs_next;
    logic [15:0] len_reg,     len_next;
    logic        bcast_reg,   bcast_next;
    logic        foreign_reg, foreign_next;
    logic [7:0]  srcep_reg,   srcep_next;
    logic [7:0]  rcode_reg,   rcode_next;
    logic [7:0]  rflag_reg,   rflag_next;
    logic [15:0] rblk_reg,    rblk_next;
    logic [15:0] rofs_reg,    rofs_next;
    logic [AW-1:0] ea_reg,    ea_next;
    logic [AW-1:0] eend_reg,  eend_next;
    logic        rv_reg,      rv_next;
    logic [7:0]  rd_reg,      rd_next;
    logic        rl_reg,      rl_next;
    logic        rdy_reg,     rdy_next;
    logic        ev_done, ev_drop, ev_err;
    logic        mem_we;

    // Software control lives in the APB section below
    logic [31:0] ctrl_reg;
    logic        enable;
    assign enable = ctrl_reg[0];

    // Next-state logic of the interpreter
    always_comb begin
        state_next   = state_reg;
        idx_next     = idx_reg;
        code_next    = code_reg;
        opt_next     = opt_reg;
        blk_next     = blk_reg;
        ofs_next     = ofs_reg;
        len_next     = len_reg;
        bcast_next   = bcast_reg;
        foreign_next = foreign_reg;
        srcep_next   = srcep_reg;
        rcode_next   = rcode_reg;
        rflag_next   = rflag_reg;
        rblk_next    = rblk_reg;
        rofs_next    = rofs_reg;
        ea_next      = ea_reg;
        eend_next    = eend_reg;
        rv_next      = rv_reg;
        rd_next      = rd_reg;
        rl_next      = rl_reg;
        rdy_next     = 1'b0;
        ev_done      = 1'b0;
        ev_drop      = 1'b0;
        ev_err       = 1'b0;
        mem_we       = 1'b0;
        unique case (state_reg)
            FSC_IDLE: begin
                idx_next = 4'h0;
                if (enable) begin
                    rdy_next   = 1'b1;
                    state_next = FSC_RECV;
                end
            end
            FSC_RECV: begin
                rdy_next = 1'b1;
                if (REQ_VALID && rdy_reg) begin
                    if (idx_reg == 4'h0) begin
                        // Frames for other services are swallowed without a response but raise the drop event
                        foreign_next = (REQ_CLUSTER != SERVICE_CLUSTER) ||
                                       (REQ_DST_EP != SERVICE_ENDPOINT);
                        bcast_next   = REQ_BCAST;
                        srcep_next   = REQ_SRC_EP;
                        code_next    = REQ_DATA;
                    end
                    unique case (idx_reg)
                        OFS_OPTION:    opt_next        = REQ_DATA;
                        OFS_BLOCK_HI:  blk_next[15:8]  = REQ_DATA;
                        OFS_BLOCK_LO:  blk_next[7:0]   = REQ_DATA;
                        OFS_OFFSET_HI: ofs_next[15:8]  = REQ_DATA;
                        OFS_OFFSET_LO: ofs_next[7:0]   = REQ_DATA;
                        OFS_LENGTH_HI: len_next[15:8]  = REQ_DATA;
                        OFS_LENGTH_LO: len_next[7:0]   = REQ_DATA;
                        default: ;
                    endcase
                    // Payload bytes past the header are neither counted nor kept: the index stops at HDR_BYTES
                    if (idx_reg < 4'(HDR_BYTES)) begin
                        idx_next = idx_reg + 4'h1;
                    end
                    if (REQ_LAST) begin
                        rdy_next   = 1'b0;
                        state_next = FSC_EXEC;
                    end
                end
            end
            FSC_EXEC: begin
                rcode_next = code_reg | RSP_FLAG_BIT;
                rblk_next  = blk_reg;
                rofs_next  = ofs_reg;
                rflag_next = 8'h00;
                state_next = FSC_SEND;
                if (foreign_reg) begin
                    ev_drop    = 1'b1;
                    state_next = FSC_IDLE;
                end else if (idx_reg < 4'(HDR_BYTES)) begin
                    // Short header: fail, echoing the code
                    rflag_next[FLAG_ERROR_POS] = 1'b1;
                end else if (code_reg == CMD_GEOMETRY) begin
                    rcode_next = RSP_GEOMETRY;
                    rblk_next  = 16'(NBLK);
                    rofs_next  = 16'(BSZ);
                end else if (code_reg == CMD_ERASE) begin
                    rcode_next = RSP_ERASE;
                    if (len_reg == 16'h0000) begin
                        ea_next    = '0;
                        eend_next  = AW'(MEMW - 1);
                        state_next = FSC_ERASE;
                    end else if (blk_reg >= 16'(NBLK)) begin
                        rflag_next[FLAG_ERROR_POS] = 1'b1;
                    end else begin
                        ea_next    = AW'(blk_reg * BSZ);
                        eend_next  = AW'(blk_reg * BSZ + BSZ - 1);
                        state_next = FSC_ERASE;
                    end
                end else begin
                    // Unsupported command code fails
                    rflag_next[FLAG_ERROR_POS] = 1'b1;
                end
                if (!foreign_reg && rflag_next[FLAG_ERROR_POS]) begin
                    ev_err = 1'b1;
                end
                idx_next = 4'h0;
            end
            FSC_ERASE: begin
                // One byte per cycle: a full wipe takes the whole array length
                mem_we  = 1'b1;
                ea_next = ea_reg + AW'(1);
                if (ea_reg == eend_reg) begin
                    state_next = FSC_SEND;
                end
            end
            FSC_SEND: begin
                if (bcast_reg) begin
                    ev_done    = 1'b1;
                    state_next = FSC_IDLE;
                end else if (!rv_reg || RSP_READY) begin
                    if (rv_reg && rl_reg) begin
                        rv_next    = 1'b0;
                        rl_next    = 1'b0;
                        ev_done    = 1'b1;
                        state_next = FSC_IDLE;
                    end else begin
                        rv_next  = 1'b1;
                        rd_next  = hdr_byte(idx_reg, rcode_reg, rflag_reg, rblk_reg, rofs_reg, 16'h0000);
                        rl_next  = (idx_reg == OFS_LENGTH_LO);
                        idx_next = idx_reg + 4'h1;
                    end
                end
            end
            default: state_next = FSC_IDLE;
        endcase
    end

    // Interpreter registers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= FSC_IDLE;
            idx_reg     <= 4'h0;
            code_reg    <= 8'h00;
            opt_reg     <= 8'h00;
            blk_reg     <= 16'h0000;
            ofs_reg     <= 16'h0000;
            len_reg     <= 16'h0000;
            bcast_reg   <= 1'b0;
            foreign_reg <= 1'b0;
            srcep_reg   <= 8'h00;
            rcode_reg   <= 8'h00;
            rflag_reg   <= 8'h00;
            rblk_reg    <= 16'h0000;
            rofs_reg    <= 16'h0000;
            ea_reg      <= '0;
            eend_reg    <= '0;
            rv_reg      <= 1'b0;
            rd_reg      <= 8'h00;
            rl_reg      <= 1'b0;
            rdy_reg     <= 1'b0;
        end else begin
            state_reg   <= state_next;
            idx_reg     <= idx_next;
            code_reg    <= code_next;
            opt_reg     <= opt_next;
            blk_reg     <= blk_next;
            ofs_reg     <= ofs_next;
            len_reg     <= len_next;
            bcast_reg   <= bcast_next;
            foreign_reg <= foreign_next;
            srcep_reg   <= srcep_next;
            rcode_reg   <= rcode_next;
            rflag_reg   <= rflag_next;
            rblk_reg    <= rblk_next;
            rofs_reg    <= rofs_next;
            ea_reg      <= ea_next;
            eend_reg    <= eend_next;
            rv_reg      <= rv_next;
            rd_reg      <= rd_next;
            rl_reg      <= rl_next;
            rdy_reg     <= rdy_next;
        end
    end

    // Storage write and read port
    always_ff @(posedge CLK) begin
        if (mem_we) begin
            mem[ea_reg] <= ERASED_BYTE;
        end
        mem_rdata_reg <= (MEM_RADDR < 16'(MEMW)) ? mem[AW'(MEM_RADDR)] : 8'h00;
    end

    // =========================================================
    // APB slave and interrupts
    logic [31:0] ctrl_next;
    logic [2:0]  ist_reg, ist_next;
    logic [2:0]  msk_reg, msk_next;
    logic [15:0] rcnt_reg, rcnt_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic        irq_reg, irq_next;
    logic        acc;
    logic [2:0]  ev_vec;

    assign acc    = PSEL && PENABLE && !pready_reg;
    assign ev_vec = {ev_err, ev_drop, ev_done};

    // One wait state per access keeps read data registered
    always_comb begin
        ctrl_next    = ctrl_reg;
        msk_next     = msk_reg;
        rcnt_next    = rcnt_reg + {15'h0000, ev_done};
        ist_next     = ist_reg;
        prdata_next  = 32'h0000_0000;
        pready_next  = acc;
        pslverr_next = 1'b0;
        if (acc) begin
            unique case (PADDR)
                ADDR_CTRL: begin
                    if (PWRITE) ctrl_next = {31'h0, PWDATA[0]};
                    prdata_next = ctrl_reg;
                end
                ADDR_STATUS:   prdata_next = {27'h0, state_reg};
                ADDR_IRQ_STAT: begin
                    prdata_next = {29'h0, ist_reg};
                    if (!PWRITE) ist_next = 3'b000; // Read clears
                end
                ADDR_IRQ_MASK: begin
                    if (PWRITE) msk_next = PWDATA[2:0];
                    prdata_next = {29'h0, msk_reg};
                end
                ADDR_RSP_CNT:  prdata_next = {16'h0, rcnt_reg};
                default:       pslverr_next = 1'b1;
            endcase
        end
        ist_next = ist_next | ev_vec; // Set wins over clear
        irq_next = |(ist_next & msk_next);
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg    <= CTRL_RESET;
            msk_reg     <= MASK_RESET[2:0];
            ist_reg     <= 3'b000;
            rcnt_reg    <= 16'h0000;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            msk_reg     <= msk_next;
            ist_reg     <= ist_next;
            rcnt_reg    <= rcnt_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg     <= irq_next;
        end
    end

    // Outputs
    assign REQ_READY  = rdy_reg;
    assign RSP_VALID  = rv_reg;
    assign RSP_DATA   = rd_reg;
    assign RSP_LAST   = rl_reg;
    assign RSP_DST_EP = srcep_reg;
    assign MEM_RDATA  = mem_rdata_reg;
    assign PRDATA     = prdata_reg;
    assign PREADY     = pready_reg;
    assign PSLVERR    = pslverr_reg;
    assign IRQ        = irq_reg;
endmodule

/* verilog/fsc_pkg.sv */
package fsc_pkg;
    // =========================================================
    // Storage geometry
    localparam int          BLOCK_COUNT      = 119;
    localparam int          BLOCK_BYTES      = 512;
    localparam int          HDR_BYTES        = 8;

    // =========================================================
    // Header byte offsets
    localparam logic [3:0]  OFS_CODE         = 4'h0;
    localparam logic [3:0]  OFS_OPTION       = 4'h1;
    localparam logic [3:0]  OFS_BLOCK_HI     = 4'h2;
    localparam logic [3:0]  OFS_BLOCK_LO     = 4'h3;
    localparam logic [3:0]  OFS_OFFSET_HI    = 4'h4;
    localparam logic [3:0]  OFS_OFFSET_LO    = 4'h5;
    localparam logic [3:0]  OFS_LENGTH_HI    = 4'h6;
    localparam logic [3:0]  OFS_LENGTH_LO    = 4'h7;

    // =========================================================
    // Addressing and command codes
    localparam logic [15:0] SERVICE_CLUSTER  = 16'h0023;
    localparam logic [7:0]  SERVICE_ENDPOINT = 8'he6;
    localparam logic [7:0]  CMD_GEOMETRY     = 8'h00;
    localparam logic [7:0]  CMD_ERASE        = 8'h01;
    localparam logic [7:0]  RSP_GEOMETRY     = 8'h80;
    localparam logic [7:0]  RSP_ERASE        = 8'h81;
    localparam logic [7:0]  RSP_FLAG_BIT     = 8'h80;
    localparam int          FLAG_ERROR_POS   = 0;
    localparam logic [7:0]  ERASED_BYTE      = 8'hff;

    // =========================================================
    // APB register map (byte addresses)
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_STATUS      = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT    = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h0c;
    localparam logic [7:0]  ADDR_RSP_CNT     = 8'h10;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
    localparam logic [31:0] MASK_RESET       = 32'h0000_0000;
    localparam int          IRQ_DONE_POS     = 0;
    localparam int          IRQ_DROP_POS     = 1;
    localparam int          IRQ_ERR_POS      = 2;
endpackage

/* test/fsc_handler_props.sv */
`timescale 1ns/1ps
// ==========================================
// Response stream checker
module fsc_handler_chk #(
    parameter int NBLK = 119,
    parameter int BSZ  = 512
) (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        REQ_VALID,
    input wire logic [7:0]  REQ_DATA,
    input wire logic        REQ_LAST,
    input wire logic        REQ_BCAST,
    input wire logic [7:0]  REQ_SRC_EP,
    input wire logic        REQ_READY,
    input wire logic        RSP_VALID,
    input wire logic [7:0]  RSP_DATA,
    input wire logic        RSP_LAST,
    input wire logic [7:0]  RSP_DST_EP,
    input wire logic        RSP_READY
);
    logic [2:0] cnt_reg, cnt_next;
    logic       in_reg, in_next, bc_reg, bc_next;
    logic [7:0] ep_reg, ep_next, code_reg, code_next;
    // Byte position in the response, attributes of the request in flight
    always_comb begin
        cnt_next = cnt_reg;
        in_next = in_reg;
        bc_next = bc_reg;
        ep_next = ep_reg;
        code_next = code_reg;
        if (RSP_VALID && RSP_READY) begin
            cnt_next = cnt_reg + 3'h1;
        end
        if (REQ_VALID && REQ_READY) begin
            in_next = !REQ_LAST;
            if (!in_reg) begin
                bc_next = REQ_BCAST;
                ep_next = REQ_SRC_EP;
                code_next = REQ_DATA;
            end
        end
    end
    // Plain registers; the three-bit count wraps after the eighth byte
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_reg <= 3'h0;
            in_reg <= 1'b0;
            bc_reg <= 1'b0;
            ep_reg <= 8'h00;
            code_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
            in_reg <= in_next;
            bc_reg <= bc_next;
            ep_reg <= ep_next;
            code_reg <= code_next;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // ==========================================
    // Properties
    a_rsp_hold_stable: assert property (RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_DATA))
        else $error("response byte changed while stalled");
    a_last_eighth: assert property (RSP_VALID |-> RSP_LAST == (cnt_reg == 3'h7))
        else $error("response last flag misplaced");
    a_ready_drop: assert property (REQ_VALID && REQ_READY && REQ_LAST |=> !REQ_READY [*2])
        else $error("request taken past its last byte");
    a_bcast_silent: assert property (RSP_VALID |-> !bc_reg)
        else $error("response to a broadcast");
    a_ep_echo: assert property (RSP_VALID |-> RSP_DST_EP == ep_reg)
        else $error("response not aimed at source endpoint");
    a_code_mirror: assert property (RSP_VALID && cnt_reg == 3'h0 |-> RSP_DATA == (code_reg | 8'h80))
        else $error("response code wrong");
    a_status_resv: assert property (RSP_VALID && cnt_reg == 3'h1 |-> RSP_DATA[7:1] == 7'h00)
        else $error("reserved status bits set");
    a_len_zero: assert property (RSP_VALID && cnt_reg[2:1] == 2'b11 |-> RSP_DATA == 8'h00)
        else $error("response length not zero");
    a_geo_count: assert property (RSP_VALID && cnt_reg == 3'h3 && code_reg == 8'h00 |-> RSP_DATA == NBLK[7:0])
        else $error("geometry block count wrong");
    c_geometry: cover property (RSP_VALID && cnt_reg == 3'h0 && RSP_DATA == 8'h80);
    c_erase: cover property (RSP_VALID && cnt_reg == 3'h0 && RSP_DATA == 8'h81);
    c_stall: cover property (RSP_VALID && !RSP_READY);
    c_bcast: cover property (REQ_VALID && REQ_READY && REQ_BCAST);
endmodule
bind fsc_handler fsc_handler_chk #(.NBLK(NBLK), .BSZ(BSZ)) u_chk (
    .CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ_DATA(REQ_DATA), .REQ_LAST(REQ_LAST),
    .REQ_BCAST(REQ_BCAST), .REQ_SRC_EP(REQ_SRC_EP), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .RSP_LAST(RSP_LAST), .RSP_DST_EP(RSP_DST_EP), .RSP_READY(RSP_READY)
);

/* test/fsc_requester.sv */
`timescale 1ns/1ps
// ==========================================
// Requesting node model
module fsc_requester (
    input  wire logic        clk,
    output logic             req_valid,
    output logic [7:0]       req_data,
    output logic             req_last,
    output logic [15:0]      req_cluster,
    output logic [7:0]       req_dst_ep,
    output logic [7:0]       req_src_ep,
    output logic             req_bcast,
    input  wire logic        req_ready,
    input  wire logic        rsp_valid,
    input  wire logic [7:0]  rsp_data,
    input  wire logic [7:0]  rsp_dst_ep,
    output logic             rsp_ready
);
    import fsc_pkg::*;
    int         rsp_total = 0;
    logic [7:0] rsp_byte [8];
    logic [7:0] rsp_ep;
    logic [3:0] pace = 4'h0;
    // Idle values at time zero
    initial begin
        req_valid = 1'b0;
        req_data = 8'h00;
        req_last = 1'b0;
        req_cluster = SERVICE_CLUSTER;
        req_dst_ep = SERVICE_ENDPOINT;
        req_src_ep = 8'h5a;
        req_bcast = 1'b0;
        rsp_ready = 1'b0;
    end
    // Stall one cycle in four so held response bytes get exercised
    always @(posedge clk) begin
        pace <= pace + 4'h1;
        rsp_ready <= pace[1:0] != 2'b11;
        if (rsp_valid && rsp_ready) begin
            rsp_byte[rsp_total % 8] <= rsp_data;
            rsp_ep <= rsp_dst_ep;
            rsp_total <= rsp_total + 1;
        end
    end
    // One eight-byte header, option and offset zero, fields MSB first
    task automatic send(input logic [7:0] code, input logic [15:0] blk, input logic [15:0] len,
                        input logic [15:0] cl, input logic bc, output logic ok);
        logic [63:0] w;
        int          n;
        w = {code, 8'h00, blk, 16'h0000, len};
        ok = 1'b1;
        @(posedge clk);
        req_cluster <= cl;
        req_bcast <= bc;
        for (int i = 0; i < 8; i++) begin
            req_valid <= 1'b1;
            req_data <= w[63 - 8 * i -: 8];
            req_last <= (i == 7);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (req_ready !== 1'b1 && n < 3000);
            if (n >= 3000) ok = 1'b0;
        end
        req_valid <= 1'b0;
        req_last <= 1'b0;
        req_data <= ~w[7:0]; // Released byte lane shows no stale value
    endtask
endmodule

/* test/fsc_handler_bench.sv */
`timescale 1ns/1ps
// ==========================================
// Top of the bench
module fsc_handler_bench;
    import fsc_pkg::*;
    localparam int NB = 4; // Few blocks keep the full erase short
    logic        CLK, RSTN, REQ_VALID, REQ_LAST, REQ_BCAST, REQ_READY, RSP_VALID, RSP_LAST, RSP_READY;
    logic [7:0]  REQ_DATA, REQ_DST_EP, REQ_SRC_EP, RSP_DATA, RSP_DST_EP, MEM_RDATA, PADDR;
    logic [15:0] REQ_CLUSTER, MEM_RADDR;
    logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
    logic [31:0] PWDATA, PRDATA, rd;
    logic        err;
    int          fail_count = 0;
    int          checked = 0;
    fsc_handler #(.NBLK(NB), .BSZ(BLOCK_BYTES)) dut (
        .CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ_DATA(REQ_DATA), .REQ_LAST(REQ_LAST),
        .REQ_CLUSTER(REQ_CLUSTER), .REQ_DST_EP(REQ_DST_EP), .REQ_SRC_EP(REQ_SRC_EP), .REQ_BCAST(REQ_BCAST),
        .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RSP_LAST(RSP_LAST),
        .RSP_DST_EP(RSP_DST_EP), .RSP_READY(RSP_READY), .MEM_RADDR(MEM_RADDR), .MEM_RDATA(MEM_RDATA),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
    fsc_requester req (
        .clk(CLK), .req_valid(REQ_VALID), .req_data(REQ_DATA), .req_last(REQ_LAST), .req_cluster(REQ_CLUSTER),
        .req_dst_ep(REQ_DST_EP), .req_src_ep(REQ_SRC_EP), .req_bcast(REQ_BCAST), .req_ready(REQ_READY),
        .rsp_valid(RSP_VALID), .rsp_data(RSP_DATA), .rsp_dst_ep(RSP_DST_EP), .rsp_ready(RSP_READY));
    // 100 MHz clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // ==========================================
    // Tasks
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // APB transfer: setup, then access held until PREADY at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            report_and_stop();
        end
    endtask
    // Send one request, then expect eight response bytes or silence
    task automatic frame(input logic [7:0] code, input logic [15:0] blk, input logic [15:0] len,
                         input logic [15:0] cl, input logic bc, input logic [63:0] exp);
        int   base;
        int   n;
        logic ok;
        base = req.rsp_total;
        req.send(code, blk, len, cl, bc, ok);
        chk(ok, 1'b1);
        n = 0;
        while (req.rsp_total < base + 8 && n < (bc || cl != SERVICE_CLUSTER ? 50 : 3000)) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 3000) begin
            fail_count++;
            report_and_stop();
        end
        chk(req.rsp_total - base, (bc || cl != SERVICE_CLUSTER) ? 0 : 8);
        if (!bc && cl == SERVICE_CLUSTER) begin
            for (int i = 0; i < 8; i++) chk(req.rsp_byte[i], exp[63 - 8 * i -: 8]);
            chk(req.rsp_ep, 8'h5a);
        end
    endtask
    // Storage byte port answers one cycle after the address
    task automatic mem(input logic [15:0] a, input logic [7:0] exp);
        @(posedge CLK);
        MEM_RADDR <= a;
        @(posedge CLK);
        @(posedge CLK);
        chk(MEM_RDATA, exp);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        RSTN = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        MEM_RADDR = 16'h0000;
        repeat (12) @(posedge CLK);
        RSTN <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        apb(1'b0, ADDR_IRQ_MASK, 32'h0);
        chk(rd, MASK_RESET);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        frame(CMD_GEOMETRY, 16'h0, 16'h0, SERVICE_CLUSTER, 1'b1, 64'h0);
        chk(IRQ, 1'b0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h7);
        frame(CMD_GEOMETRY, 16'h0, 16'h0, 16'h0024, 1'b0, 64'h0);
        repeat (3) @(posedge CLK);
        chk(IRQ, 1'b1);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h0);
        chk(IRQ, 1'b0);
        frame(CMD_GEOMETRY, 16'h0, 16'h0, SERVICE_CLUSTER, 1'b0,
              {RSP_GEOMETRY, 8'h00, 16'(NB), 16'(BLOCK_BYTES), 16'h0});
        frame(CMD_ERASE, 16'h2, 16'(BLOCK_BYTES), SERVICE_CLUSTER, 1'b0,
              {RSP_ERASE, 8'h00, 16'h2, 16'h0, 16'h0});
        mem(16'h0400, ERASED_BYTE);
        mem(16'h05ff, ERASED_BYTE);
        frame(CMD_ERASE, 16'(NB), 16'(BLOCK_BYTES), SERVICE_CLUSTER, 1'b0,
              {RSP_ERASE, 8'h01, 16'(NB), 16'h0, 16'h0});
        frame(CMD_ERASE, 16'h3, 16'h0, SERVICE_CLUSTER, 1'b0,
              {RSP_ERASE, 8'h00, 16'h3, 16'h0, 16'h0});
        mem(16'h0000, ERASED_BYTE);
        mem(16'h07ff, ERASED_BYTE);
        mem(16'h0800, 8'h00);
        apb(1'b0, ADDR_RSP_CNT, 32'h0);
        chk(rd, 32'h5);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        report_and_stop();
    end
endmodule
